/* logic/bpl_pkg.sv */
package bpl_pkg;
	localparam logic [4:0]  ADDR_TALLY      = 5'h15;
	localparam logic [4:0]  ADDR_CTRL       = 5'h16;
	localparam logic [4:0]  ADDR_STAT       = 5'h17;
	localparam logic [4:0]  ADDR_CTL_STATUS = 5'h1f;
	localparam int          CTRL_CONT_BIT   = 15;
	localparam int          CTRL_RAND_BIT   = 14;
	localparam int          CTRL_SHORT_BIT  = 13;
	localparam int          CTRL_GEN_BIT    = 12;
	localparam int          CTRL_RXFWD_BIT  = 7;
	localparam int          CTRL_TXFWD_BIT  = 6;
	localparam logic [15:0] CTRL_WMASK      = 16'hf0ff;
	localparam logic [15:0] CTRL_RESET      = 16'h0000;
	localparam logic [15:0] TALLY_RESET     = 16'h0000;
	localparam int          STAT_SYNC_BIT   = 11;
	localparam int          STAT_LOST_BIT   = 10;
	localparam int          STAT_BUSY_BIT   = 9;
	localparam int          STAT_LEGM_BIT   = 8;
	localparam int          STAT_LEGS_BIT   = 7;
	localparam int          STAT_PWR_BIT    = 6;
	localparam logic [3:0]  LOOP_REV        = 4'h8;
	localparam logic [3:0]  LOOP_EXT        = 4'h4;
	localparam logic [3:0]  LOOP_ANA        = 4'h2;
	localparam logic [3:0]  LOOP_DIG        = 4'h1;
	localparam logic [1:0]  PCS_AFTER_ENC   = 2'h3;
	localparam logic [1:0]  PCS_MID         = 2'h2;
	localparam logic [1:0]  PCS_BEFORE      = 2'h1;
	localparam logic [10:0] PKT_SHORT_LAST  = 11'd63;
	localparam logic [10:0] PKT_LONG_LAST   = 11'd1517;
	localparam logic [3:0]  LOCK_LAST       = 4'd7;
	localparam logic [7:0]  LFSR_SEED       = 8'h01;
	localparam logic [7:0]  CONST_BYTE      = 8'h55;

	typedef enum logic [2:0] {
		G_IDLE = 3'b001,
		G_SEND = 3'b010,
		G_DONE = 3'b100
	} bpl_gen_e;

	typedef enum logic [5:0] {
		C_IDLE = 6'b000001,
		C_PRE  = 6'b000010,
		C_PREW = 6'b000100,
		C_ISS  = 6'b001000,
		C_ISSW = 6'b010000,
		C_DONE = 6'b100000
	} bpl_ctl_e;

	// x^8+x^6+x^5+x^4+1, one step per byte; checker self-seeds from data
	function automatic logic [7:0] bpl_lfsr_next(input logic [7:0] b);
		bpl_lfsr_next = {b[6:0], b[7] ^ b[5] ^ b[4] ^ b[3]};
	endfunction
endpackage

/* logic/bpl_link_if.sv */
`timescale 1ns/100ps
interface bpl_link_if;
	logic        req;
	logic        we;
	logic [4:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        ack;

	modport dev (input req, we, addr, wdata, output rdata, ack);
	modport ctl (output req, we, addr, wdata, input rdata, ack);
endinterface

/* logic/bpl_counter.sv */
`timescale 1ns/100ps
module bpl_counter #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// control
	input  wire logic             i_inc,
	input  wire logic             i_clr,
	input  wire logic             i_wrap,
	// result
	output logic [WIDTH-1:0]      o_count,
	output logic                  o_wrap_pulse
);
	logic [WIDTH-1:0] cnt_q;
	logic             pulse_q;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cnt_q   <= '0;
			pulse_q <= 1'b0;
		end
		else
		begin
			pulse_q <= 1'b0;
			// an event in the clearing cycle still counts
			if (i_clr)
				cnt_q <= {{(WIDTH-1){1'b0}}, i_inc};
			else if (i_inc)
			begin
				if (cnt_q != {WIDTH{1'b1}})
					cnt_q <= cnt_q + 1'b1;
				else if (i_wrap)
				begin
					cnt_q   <= '0;
					pulse_q <= 1'b1;
				end
				// otherwise hold at all ones
			end
		end
	end

	assign o_count      = cnt_q;
	assign o_wrap_pulse = pulse_q;
endmodule // bpl_counter

/* logic/bpl_dev.sv */
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module bpl_dev
	import bpl_pkg::*;
(
	// clock and reset
	input  wire logic    I_MCLK,
	input  wire logic    I_RST,
	// register link
	bpl_link_if.dev      bus,
	// receive path and core state
	input  wire logic    I_RX_ER,
	input  wire logic    I_CHK_VALID,
	input  wire logic [7:0] I_CHK_DATA,
	input  wire logic    I_SPEED_1G,
	input  wire logic    I_LEGACY_MASTER,
	input  wire logic    I_LEGACY_SLAVE,
	input  wire logic    I_CORE_NORMAL,
	// generator stream and checker wrap
	output logic         O_TX_EN,
	output logic [7:0]   O_TX_DATA,
	output logic         O_CHK_WRAP,
	// loop controls
	output logic [3:0]   O_LOOP_SEL,
	output logic [2:0]   O_PCS_TAP,
	output logic         O_GIG_PCS_LOOP,
	output logic         O_RX_TO_MAC,
	output logic         O_TX_TO_LINE
);
	logic [15:0] ctrl_q;
	logic        ack_q;
	logic [15:0] rdata_q;
	logic [15:0] rd_val;
	logic [15:0] stat_word;
	logic [15:0] tally;
	logic        wr_tally;
	logic        wr_ctrl;
	logic        rd_stat;
	bpl_gen_e    gen_q;
	logic [10:0] byte_q;
	logic [10:0] pkt_last;
	logic [7:0]  lfsr_q;
	logic        tx_en_q;
	logic [7:0]  tx_data_q;
	logic [7:0]  pred_q;
	logic [3:0]  match_q;
	logic        sync_q;
	logic        lost_q;
	logic        chk_on;
	logic        chk_hit;
	logic        chk_miss;
	logic [15:0] chk_bytes;
	logic [15:0] chk_errs;
	logic        wrap_a;
	logic        wrap_b;
	logic        wrap_q;
	logic [3:0]  loop_q;
	logic [2:0]  tap_q;
	logic        gig_q;
	logic        rxfwd_q;
	logic        txfwd_q;
	logic        cont;
	logic        rand_sel;
	logic        gen_en;

	assign cont     = ctrl_q[CTRL_CONT_BIT];
	assign rand_sel = ctrl_q[CTRL_RAND_BIT];
	assign gen_en   = ctrl_q[CTRL_GEN_BIT];

	////////////////////////////////////////////////////////////////////////
	// register access: answer one cycle after the request

	assign wr_tally = bus.req & bus.we & (bus.addr == ADDR_TALLY);
	assign wr_ctrl  = bus.req & bus.we & (bus.addr == ADDR_CTRL);
	assign rd_stat  = bus.req & ~bus.we & (bus.addr == ADDR_STAT);

	always_comb
	begin
		stat_word                = 16'h0000;
		stat_word[STAT_SYNC_BIT] = sync_q;
		stat_word[STAT_LOST_BIT] = lost_q;
		stat_word[STAT_BUSY_BIT] = (gen_q == G_SEND);
		stat_word[STAT_LEGM_BIT] = I_LEGACY_MASTER;
		stat_word[STAT_LEGS_BIT] = I_LEGACY_SLAVE;
		stat_word[STAT_PWR_BIT]  = I_CORE_NORMAL;
	end

	always_comb
	begin
		if (bus.addr == ADDR_TALLY)
			rd_val = tally;
		else if (bus.addr == ADDR_CTRL)
			rd_val = ctrl_q;
		else if (bus.addr == ADDR_STAT)
			rd_val = stat_word;
		else
			rd_val = 16'h0000;
	end

	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else
		begin
			ack_q <= bus.req;
			if (bus.req && !bus.we)
				rdata_q <= rd_val;
		end
	end

	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
			ctrl_q <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= bus.wdata & CTRL_WMASK;
	end

	assign bus.ack   = ack_q;
	assign bus.rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// receive error tally: write data is thrown away, only the strobe counts

	bpl_counter #(.WIDTH(16)) u_tally (
		.i_clk        (I_MCLK),
		.i_rst        (I_RST),
		.i_inc        (I_RX_ER),
		.i_clr        (wr_tally),
		.i_wrap       (1'b0),
		.o_count      (tally),
		.o_wrap_pulse ()
	);

	////////////////////////////////////////////////////////////////////////
	// packet generator

	assign pkt_last = ctrl_q[CTRL_SHORT_BIT] ? PKT_SHORT_LAST
		: PKT_LONG_LAST;

	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			gen_q  <= G_IDLE;
			byte_q <= 11'd0;
		end
		else
		begin
			case (gen_q)
				G_IDLE:
				begin
					byte_q <= 11'd0;
					if (gen_en)
						gen_q <= G_SEND;
				end
				G_SEND:
				begin
					if (!gen_en)
						gen_q <= G_IDLE;
					else if (byte_q == pkt_last)
					begin
						byte_q <= 11'd0;
						// random mode restarts at once: back-to-back
						gen_q  <= rand_sel ? G_SEND : G_DONE;
					end
					else
						byte_q <= byte_q + 11'd1;
				end
				G_DONE:
				begin
					// single packet sent; re-arm only through enable low
					if (!gen_en)
						gen_q <= G_IDLE;
				end
				default:
					gen_q <= G_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			lfsr_q    <= LFSR_SEED;
			tx_en_q   <= 1'b0;
			tx_data_q <= 8'h00;
		end
		else
		begin
			tx_en_q   <= (gen_q == G_SEND) && gen_en;
			tx_data_q <= rand_sel ? lfsr_q : CONST_BYTE;
			if (gen_q == G_SEND && rand_sel)
				lfsr_q <= bpl_lfsr_next(lfsr_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checker: independent of the generator, off without random select

	assign chk_on   = rand_sel;
	assign chk_hit  = chk_on & I_CHK_VALID & (I_CHK_DATA == pred_q);
	assign chk_miss = chk_on & I_CHK_VALID & (I_CHK_DATA != pred_q);

	always_ff @(posedge I_MCLK)
	begin
		if (I_RST || !chk_on)
		begin
			pred_q  <= 8'h00;
			match_q <= 4'd0;
			sync_q  <= 1'b0;
		end
		else if (I_CHK_VALID)
		begin
			pred_q <= bpl_lfsr_next(I_CHK_DATA);
			if (chk_miss)
			begin
				match_q <= 4'd0;
				sync_q  <= 1'b0;
			end
			else if (!sync_q)
			begin
				if (match_q == LOCK_LAST)
					sync_q <= 1'b1;
				else
					match_q <= match_q + 4'd1;
			end
		end
	end

	// a loss in the reading cycle survives the read
	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
			lost_q <= 1'b0;
		else
			lost_q <= (chk_miss & sync_q) | (lost_q & ~rd_stat);
	end

	bpl_counter #(.WIDTH(16)) u_chk_bytes (
		.i_clk        (I_MCLK),
		.i_rst        (I_RST),
		.i_inc        (chk_hit & sync_q),
		.i_clr        (~chk_on),
		.i_wrap       (cont),
		.o_count      (chk_bytes),
		.o_wrap_pulse (wrap_a)
	);

	bpl_counter #(.WIDTH(16)) u_chk_errs (
		.i_clk        (I_MCLK),
		.i_rst        (I_RST),
		.i_inc        (chk_miss),
		.i_clr        (~chk_on),
		.i_wrap       (cont),
		.o_count      (chk_errs),
		.o_wrap_pulse (wrap_b)
	);

	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
			wrap_q <= 1'b0;
		else
			wrap_q <= wrap_a | wrap_b;
	end

	////////////////////////////////////////////////////////////////////////
	// loop point controls; undefined codes select no loop

	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			loop_q  <= 4'h0;
			tap_q   <= 3'h0;
			gig_q   <= 1'b0;
			rxfwd_q <= 1'b1;
			txfwd_q <= 1'b1;
		end
		else
		begin
			if (ctrl_q[5:2] == LOOP_REV || ctrl_q[5:2] == LOOP_EXT
				|| ctrl_q[5:2] == LOOP_ANA || ctrl_q[5:2] == LOOP_DIG)
				loop_q <= ctrl_q[5:2];
			else
				loop_q <= 4'h0;
			tap_q[2] <= !I_SPEED_1G && ctrl_q[1:0] == PCS_AFTER_ENC;
			tap_q[1] <= !I_SPEED_1G && ctrl_q[1:0] == PCS_MID;
			tap_q[0] <= !I_SPEED_1G && ctrl_q[1:0] == PCS_BEFORE;
			gig_q    <= I_SPEED_1G && ctrl_q[0];
			rxfwd_q  <= ctrl_q[5:2] != LOOP_REV
				|| ctrl_q[CTRL_RXFWD_BIT];
			txfwd_q  <= ctrl_q[5:2] != LOOP_DIG
				|| ctrl_q[CTRL_TXFWD_BIT];
		end
	end

	assign O_TX_EN        = tx_en_q;
	assign O_TX_DATA      = tx_data_q;
	assign O_CHK_WRAP     = wrap_q;
	assign O_LOOP_SEL     = loop_q;
	assign O_PCS_TAP      = tap_q;
	assign O_GIG_PCS_LOOP = gig_q;
	assign O_RX_TO_MAC    = rxfwd_q;
	assign O_TX_TO_LINE   = txfwd_q;
endmodule // bpl_dev

/* logic/bpl_ctl.sv */
`timescale 1ns/100ps
module bpl_ctl
	import bpl_pkg::*;
(
	// clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_RST,
	// avalon-mm slave, word addressed
	input  wire logic [4:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0]      O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	// device link
	bpl_link_if.ctl          link
);
	bpl_ctl_e    st_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic        req_q;
	logic        we_q;
	logic        pend_we_q;
	logic [4:0]  addr_q;
	logic [15:0] wdata_q;
	logic [15:0] pend_q;
	logic [15:0] shadow_q;
	logic [1:0]  fix_q;
	logic [15:0] adj;
	logic        is_dev;
	logic        need_pre;

	// the controller enforces the software duties on control writes
	always_comb
	begin
		adj = I_AVS_WRITEDATA[15:0] & CTRL_WMASK;
		if (adj[CTRL_GEN_BIT] || adj[CTRL_RAND_BIT])
			adj[CTRL_CONT_BIT] = 1'b1;
		if (adj[5:2] != LOOP_REV)
			adj[CTRL_RXFWD_BIT] = 1'b0;
		if (adj[5:2] != LOOP_DIG)
			adj[CTRL_TXFWD_BIT] = 1'b0;
	end

	assign is_dev   = I_AVS_ADDRESS == ADDR_TALLY || I_AVS_ADDRESS == ADDR_CTRL
		|| I_AVS_ADDRESS == ADDR_STAT;
	assign need_pre = I_AVS_WRITE && I_AVS_ADDRESS == ADDR_CTRL
		&& adj[5:2] != 4'h0 && shadow_q[1:0] != 2'h0;

	////////////////////////////////////////////////////////////////////////

	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
		begin
			st_q      <= C_IDLE;
			wait_q    <= 1'b1;
			rdata_q   <= 32'h00000000;
			req_q     <= 1'b0;
			we_q      <= 1'b0;
			pend_we_q <= 1'b0;
			addr_q    <= 5'h00;
			wdata_q   <= 16'h0000;
			pend_q    <= 16'h0000;
			shadow_q  <= CTRL_RESET;
			fix_q     <= 2'h0;
		end
		else
		begin
			case (st_q)
				C_IDLE:
				begin
					if (I_AVS_READ || I_AVS_WRITE)
					begin
						if (is_dev)
						begin
							addr_q    <= I_AVS_ADDRESS;
							pend_we_q <= I_AVS_WRITE;
							pend_q    <= (I_AVS_ADDRESS == ADDR_CTRL)
								? adj : I_AVS_WRITEDATA[15:0];
							if (I_AVS_WRITE && I_AVS_ADDRESS == ADDR_CTRL)
								fix_q <= {need_pre, adj != I_AVS_WRITEDATA[15:0]};
							st_q <= need_pre ? C_PRE : C_ISS;
						end
						else
						begin
							// own status reads the fix flags, unmapped reads zero; write dropped
							rdata_q <= (I_AVS_ADDRESS == ADDR_CTL_STATUS)
								? {30'h0, fix_q} : 32'h00000000;
							wait_q  <= 1'b0;
							st_q    <= C_DONE;
						end
					end
				end
				C_PRE:
				begin
					req_q   <= 1'b1;
					we_q    <= 1'b1;
					wdata_q <= {shadow_q[15:2], 2'h0};
					st_q    <= C_PREW;
				end
				C_PREW:
				begin
					req_q <= 1'b0;
					if (link.ack)
					begin
						shadow_q <= wdata_q;
						st_q     <= C_ISS;
					end
				end
				C_ISS:
				begin
					req_q   <= 1'b1;
					we_q    <= pend_we_q;
					wdata_q <= pend_q;
					st_q    <= C_ISSW;
				end
				C_ISSW:
				begin
					req_q <= 1'b0;
					if (link.ack)
					begin
						rdata_q <= {16'h0000, link.rdata};
						if (we_q && addr_q == ADDR_CTRL)
							shadow_q <= wdata_q;
						wait_q  <= 1'b0;
						st_q    <= C_DONE;
					end
				end
				C_DONE:
				begin
					wait_q <= 1'b1;
					st_q   <= C_IDLE;
				end
				default:
					st_q <= C_IDLE;
			endcase
		end
	end

	assign link.req          = req_q;
	assign link.we           = we_q;
	assign link.addr         = addr_q;
	assign link.wdata        = wdata_q;
	assign O_AVS_READDATA    = rdata_q;
	assign O_AVS_WAITREQUEST = wait_q;
endmodule // bpl_ctl

/* bench/bpl_sva.sv */
`timescale 1ns/100ps
module bpl_sva
	import bpl_pkg::*;
(
	// clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_RST,
	// link signals
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [4:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        ack
);
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_RST);
	logic        rd_q;
	logic [4:0]  addr_q;
	logic        have_q;
	logic [15:0] last_q;
	logic [15:0] ctrl_q;
	wire         wr_ctl = req && we && addr == ADDR_CTRL;
	wire         rd_ack = ack && rd_q;
	wire         rd_tly = rd_ack && addr_q == ADDR_TALLY;
	////////////////////////////////////////
	always_ff @(posedge I_MCLK)
	begin
		rd_q   <= !I_RST && req && !we;
		addr_q <= addr;
	end
	// any clear forgets the last tally so a drop after it is not a wrap
	always_ff @(posedge I_MCLK)
	begin
		if (I_RST || (req && we && addr == ADDR_TALLY))
			have_q <= 1'b0;
		else if (rd_tly)
			have_q <= 1'b1;
	end
	always_ff @(posedge I_MCLK)
	begin
		if (rd_tly)
			last_q <= rdata;
	end
	always_ff @(posedge I_MCLK)
	begin
		if (I_RST)
			ctrl_q <= 16'h0000;
		else if (wr_ctl)
			ctrl_q <= wdata;
	end
	////////////////////////////////////////
	a_ack_after_req: assert property (req |=> ack)
		else $error("link request not acknowledged");
	a_ack_has_req: assert property (ack |-> $past(req))
		else $error("link ack without request");
	a_req_one_cycle: assert property (req |=> !req)
		else $error("link request longer than one cycle");
	a_ctrl_rsvd_zero: assert property (
		rd_ack && addr_q == ADDR_CTRL |-> rdata[11:8] == 4'h0)
		else $error("control reserved bits not zero");
	a_stat_rsvd_zero: assert property (rd_ack && addr_q == ADDR_STAT
		|-> rdata[15:12] == 4'h0 && rdata[5:0] == 6'h00)
		else $error("status reserved bits not zero");
	a_tally_no_wrap: assert property (
		rd_tly && have_q |-> rdata >= last_q)
		else $error("error tally went down without a clear");
	a_cont_forced: assert property (
		wr_ctl && (wdata[12] || wdata[14]) |-> wdata[15])
		else $error("continuous mode not set with generator use");
	a_rxfwd_reverse: assert property (
		wr_ctl && wdata[7] |-> wdata[5:2] == LOOP_REV)
		else $error("receive forward set outside reverse loop");
	a_txfwd_digital: assert property (
		wr_ctl && wdata[6] |-> wdata[5:2] == LOOP_DIG)
		else $error("transmit forward set outside digital loop");
	a_loop_preclear: assert property (wr_ctl && wdata[5:2] != 4'h0
		&& wdata[5:2] != ctrl_q[5:2] |-> ctrl_q[1:0] == 2'h0)
		else $error("loop point written with coding loop on");
endmodule // bpl_sva

/* bench/phy_bist_loopback_control_bench.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module phy_bist_loopback_control_bench;
	import bpl_pkg::*;
	logic        clk = 0, rst = 1, rx_er = 0, chk_valid = 0, spd = 0;
	logic        lm = 0, ls = 0, cn = 0, avs_rd = 0, avs_wr = 0, bad = 0;
	logic [7:0]  chk_data = 0, lf = 8'h5a, prev;
	logic [4:0]  avs_addr = 0;
	logic [31:0] avs_wd = 0, e;
	logic        tx_en, rx_to_mac, tx_to_line, gig, waitreq, chk_wrap;
	logic [7:0]  tx_data;
	logic [3:0]  loop_sel;
	logic [2:0]  pcs_tap;
	logic [31:0] rdata;
	logic [15:0] eq[$], mq[$];
	logic        rand_mode = 0, have_prev = 0, self_feed = 0, junk = 0;
	int          fail_count = 0, cmp_count = 0, tx_cnt = 0, seed = 44574;
	int          wrap_cnt = 0;
	always #4 clk = ~clk;
	bpl_link_if bpl_link_if_i ();
	bpl_dev bpl_dev_i (.I_MCLK(clk), .I_RST(rst), .bus(bpl_link_if_i),
		.I_RX_ER(rx_er), .I_CHK_VALID(chk_valid), .I_CHK_DATA(chk_data),
		.I_SPEED_1G(spd), .I_LEGACY_MASTER(lm), .I_LEGACY_SLAVE(ls),
		.I_CORE_NORMAL(cn), .O_TX_EN(tx_en), .O_TX_DATA(tx_data),
		.O_CHK_WRAP(chk_wrap), .O_LOOP_SEL(loop_sel), .O_PCS_TAP(pcs_tap),
		.O_GIG_PCS_LOOP(gig), .O_RX_TO_MAC(rx_to_mac),
		.O_TX_TO_LINE(tx_to_line));
	bpl_ctl bpl_ctl_i (.I_MCLK(clk), .I_RST(rst), .I_AVS_ADDRESS(avs_addr),
		.I_AVS_READ(avs_rd), .I_AVS_WRITE(avs_wr), .I_AVS_WRITEDATA(avs_wd),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
		.link(bpl_link_if_i));
	bpl_sva bpl_sva_i (.I_MCLK(clk), .I_RST(rst), .req(bpl_link_if_i.req),
		.we(bpl_link_if_i.we), .addr(bpl_link_if_i.addr),
		.wdata(bpl_link_if_i.wdata), .rdata(bpl_link_if_i.rdata),
		.ack(bpl_link_if_i.ack));
	////////////////////////////////////////
	function automatic logic [7:0] nxt(input logic [7:0] b);
		return {b[6:0], b[7] ^ b[5] ^ b[4] ^ b[3]};
	endfunction
	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic acc(input logic [4:0] a, input logic w, input logic [15:0] d);
		int n;
		@(posedge clk);
		avs_addr <= a;
		avs_wr <= w;
		avs_rd <= !w;
		avs_wd <= {16'h0000, d};
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (waitreq === 1'b0)
				break;
		end
		avs_wr <= 1'b0;
		avs_rd <= 1'b0;
		if (n == 50)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t no answer", $time);
			stop_test();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		acc(a, 1'b1, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] x, input logic [15:0] m);
		eq.push_back(x);
		mq.push_back(m);
		acc(a, 1'b0, 16'h0000);
	endtask
	////////////////////////////////////////
	always @(posedge clk)
		if (avs_rd && waitreq === 1'b0)
		begin
			e = {16'hffff, mq.pop_front()};
			`CHK(rdata & e, {16'h0000, eq.pop_front()})
		end
	always @(posedge clk)
		if (tx_en === 1'b1)
		begin
			tx_cnt++;
			if (rand_mode && have_prev)
				`CHK(tx_data, nxt(prev))
			else if (!rand_mode)
				`CHK(tx_data, CONST_BYTE)
			prev = tx_data;
			have_prev = 1'b1;
		end
	// loop the generator back, or feed an own stream once it is stopped
	always @(posedge clk)
		if (junk)
		begin
			// constant ones never follow the sequence: a miss every byte
			chk_data <= 8'hff;
			chk_valid <= 1'b1;
		end
		else if (self_feed)
		begin
			lf <= nxt(lf);
			chk_data <= lf;
			chk_valid <= 1'b1;
		end
		else
		begin
			chk_valid <= tx_en;
			chk_data <= tx_data ^ {8{bad}};
		end
	always @(posedge clk)
		if (chk_wrap === 1'b1)
			wrap_cnt++;
	initial
	begin
		repeat (90000) @(posedge clk);
		fail_count++;
		stop_test();
	end
	initial
	begin
		int n, c;
		logic [3:0] code;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		lm <= 1'($random(seed));
		ls <= 1'($random(seed));
		cn <= 1'b1;
		@(posedge clk);
		rd(ADDR_CTRL, 16'h0000, 16'hffff);
		rd(ADDR_STAT, {7'h00, lm, ls, cn, 6'h00}, 16'hffff);
		wr(5'h03, 16'hffff);
		rd(5'h03, 16'h0000, 16'hffff);
		n = 2 + ($random(seed) & 15);
		rx_er <= 1'b1;
		repeat (n) @(posedge clk);
		rx_er <= 1'b0;
		rd(ADDR_TALLY, 16'(n), 16'hffff);
		wr(ADDR_TALLY, 16'($random(seed)));
		rd(ADDR_TALLY, 16'h0000, 16'hffff);
		// checker on with misses, so its error counter wraps meanwhile
		wr(ADDR_CTRL, 16'h4000);
		rx_er <= 1'b1;
		junk <= 1'b1;
		repeat (65540) @(posedge clk);
		rx_er <= 1'b0;
		junk <= 1'b0;
		rd(ADDR_TALLY, 16'hffff, 16'hffff);
		rd(ADDR_TALLY, 16'hffff, 16'hffff);
		`CHK(wrap_cnt, 1)
		wr(ADDR_CTRL, 16'h0fa0);
		rd(ADDR_CTRL, 16'h00a0, 16'hffff);
		`CHK(rx_to_mac, 1'b1)
		wr(ADDR_CTRL, 16'h0020);
		`CHK(rx_to_mac, 1'b0)
		wr(ADDR_STAT, 16'hffff);
		rd(ADDR_STAT, {7'h00, lm, ls, cn, 6'h00}, 16'hffff);
		for (n = 1; n < 4; n++)
		begin
			wr(ADDR_CTRL, 16'(n));
			`CHK(pcs_tap, 3'h1 << (n - 1))
		end
		spd <= 1'b1;
		for (n = 1; n < 4; n++)
		begin
			wr(ADDR_CTRL, 16'(n));
			`CHK({gig, pcs_tap}, {n[0], 3'h0})
		end
		spd <= 1'b0;
		for (n = 0; n < 4; n++)
		begin
			code = 4'h1 << n;
			wr(ADDR_CTRL, {10'h000, code, 2'h0});
			`CHK(loop_sel, code)
			if (n == 0)
				rd(ADDR_CTL_STATUS, 16'h0002, 16'hffff);
			`CHK({rx_to_mac, tx_to_line}, {code != LOOP_REV, code != LOOP_DIG})
		end
		wr(ADDR_CTRL, 16'h0044);
		`CHK(tx_to_line, 1'b1)
		wr(ADDR_CTRL, 16'h0000);
		tx_cnt = 0;
		wr(ADDR_CTRL, 16'h3000);
		rd(ADDR_STAT, 16'h0200, 16'h0200);
		repeat (150) @(posedge clk);
		`CHK(tx_cnt, 64)
		rd(ADDR_STAT, 16'h0000, 16'h0200);
		wr(ADDR_CTRL, 16'h0000);
		tx_cnt = 0;
		wr(ADDR_CTRL, 16'h1000);
		repeat (1600) @(posedge clk);
		`CHK(tx_cnt, 1518)
		wr(ADDR_CTRL, 16'h0000);
		rand_mode = 1'b1;
		have_prev = 1'b0;
		tx_cnt = 0;
		wr(ADDR_CTRL, 16'h7000);
		rd(ADDR_CTRL, 16'hf000, 16'hffff);
		repeat (300) @(posedge clk);
		`CHK(tx_cnt > 200, 1'b1)
		rd(ADDR_STAT, 16'h0a00, 16'h0e00);
		bad <= 1'b1;
		@(posedge clk);
		bad <= 1'b0;
		repeat (20) @(posedge clk);
		rd(ADDR_STAT, 16'h0400, 16'h0400);
		rd(ADDR_STAT, 16'h0000, 16'h0400);
		self_feed <= 1'b1;
		wr(ADDR_CTRL, 16'h4000);
		repeat (10) @(posedge clk);
		c = tx_cnt;
		repeat (50) @(posedge clk);
		`CHK(tx_cnt, c)
		rd(ADDR_STAT, 16'h0800, 16'h0a00);
		repeat (5) @(posedge clk);
		`CHK(eq.size(), 0)
		stop_test();
	end
endmodule // phy_bist_loopback_control_bench
